// file: rtl/dual_pwm_split_cycle.sv
// Two-channel 8-bit split-cycle PWM with its shared control register
// and the general-purpose port C that its outputs share pins with.
// Assumes a plain strobe register port on the 10 MHz system clock and
// an external pad that resolves PORTC_OUT / PORTC_OE_N into the pin.
//
// Notes on behaviour
// - Bit 7 picks 7+1 (0) or 6+2 (1)
// - Bit 6 hands channel one its pin
// - Bit 5 hands channel zero its pin
// - Full period is 256 clocks
// - 6+2 gives four 64-clock sub-cycles
// - 6+2 base bits 7..2, extra 1..0
// - 6+2 sub-cycle below extra gets one more
// - 7+1 gives two 128-clock sub-cycles
// - 7+1 base bits 7..1, extra bit 0
// - 7+1 sub-cycle below extra gets one more
// - Channels share port C bits 5, 6
// - Port data 1 passes wave, 0 forces low
// - Direction 1 leaves pin an input
// - Control register all read-write, reset zero
// - Counter runs straight off system clock
// - One 8-bit duty register per channel
`default_nettype none

module dual_pwm_split_cycle #(
   parameter int NUM_CHAN = 2
) (
   input  wire logic                    REF_CLK,
   input  wire logic                    SRST,
   input  wire logic [pwm_pkg::ADDR_W-1:0] ADDR,
   input  wire logic [pwm_pkg::DATA_W-1:0] WDATA,
   input  wire logic                    WR,
   input  wire logic                    RD,
   output logic      [pwm_pkg::DATA_W-1:0] RDATA,
   input  wire logic [pwm_pkg::DATA_W-1:0] PORTC_IN,
   output logic      [pwm_pkg::DATA_W-1:0] PORTC_OUT,
   output logic      [pwm_pkg::DATA_W-1:0] PORTC_OE_N,
   output logic      [pwm_pkg::DATA_W-1:0] PORTC_PULL_EN
);
   import pwm_pkg::*;

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   // Only two pin slots exist on port C for the modulators.
   if (NUM_CHAN != 2) begin : g_bad_chan
      $error("NUM_CHAN must be 2");
   end
   // The modulators split the count into index bits over six or seven.
   if (COUNT_W != 8) begin : g_bad_count
      $error("COUNT_W must be 8");
   end
   // Registers are bytes and the channel pins sit at bits 5 and 6.
   if (DATA_W != 8) begin : g_bad_data
      $error("DATA_W must be 8");
   end

   // ----------------------------------------------------------------------
   // Software-visible state
   // ----------------------------------------------------------------------
   logic [DATA_W-1:0]  ctrl_reg;
   logic [DATA_W-1:0]  duty0_reg;
   logic [DATA_W-1:0]  duty1_reg;
   logic [DATA_W-1:0]  dir_reg;
   logic [DATA_W-1:0]  data_reg;
   logic [DATA_W-1:0]  pull_reg;
   logic [DATA_W-1:0]  rdata_reg;
   logic [DATA_W-1:0]  rdata_next;

   // ----------------------------------------------------------------------
   // Pin synchroniser and pin outputs
   // ----------------------------------------------------------------------
   logic [DATA_W-1:0]  pin_meta_reg;
   logic [DATA_W-1:0]  pin_sync_reg;
   logic [DATA_W-1:0]  pc_out_reg;
   logic [DATA_W-1:0]  pc_oe_n_reg;
   wire logic [DATA_W-1:0] pc_out_next;
   wire logic [DATA_W-1:0] pc_oe_n_next;

   // ----------------------------------------------------------------------
   // Period counter
   // ----------------------------------------------------------------------
   logic [COUNT_W-1:0] count_reg;
   wire logic          period_end;

   // ----------------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------------
   wire logic wr_ctrl;
   wire logic wr_duty0;
   wire logic wr_duty1;
   wire logic wr_dir;
   wire logic wr_data;
   wire logic wr_pull;

   // Writes to the pin and counter offsets are ignored.
   assign wr_ctrl  = WR && (ADDR == OFS_CTRL);
   assign wr_duty0 = WR && (ADDR == OFS_DUTY0);
   assign wr_duty1 = WR && (ADDR == OFS_DUTY1);
   assign wr_dir   = WR && (ADDR == OFS_PC_DIR);
   assign wr_data  = WR && (ADDR == OFS_PC_DATA);
   assign wr_pull  = WR && (ADDR == OFS_PC_PULL);

   // ----------------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------------
   // Read data appear in the cycle after the strobe and only then; a
   // cycle without a read loads zero so no stale byte lingers.
   wire logic rd_ctrl;
   wire logic rd_duty0;
   wire logic rd_duty1;
   wire logic rd_dir;
   wire logic rd_data;
   wire logic rd_pull;
   wire logic rd_pins;
   wire logic rd_count;

   assign rd_ctrl  = RD && (ADDR == OFS_CTRL);
   assign rd_duty0 = RD && (ADDR == OFS_DUTY0);
   assign rd_duty1 = RD && (ADDR == OFS_DUTY1);
   assign rd_dir   = RD && (ADDR == OFS_PC_DIR);
   assign rd_data  = RD && (ADDR == OFS_PC_DATA);
   assign rd_pull  = RD && (ADDR == OFS_PC_PULL);
   assign rd_pins  = RD && (ADDR == OFS_PC_PINS);
   assign rd_count = RD && (ADDR == OFS_COUNT);

   assign rdata_next = ({DATA_W{rd_ctrl}}  & ctrl_reg)
                     | ({DATA_W{rd_duty0}} & duty0_reg)
                     | ({DATA_W{rd_duty1}} & duty1_reg)
                     | ({DATA_W{rd_dir}}   & dir_reg)
                     | ({DATA_W{rd_data}}  & data_reg)
                     | ({DATA_W{rd_pull}}  & pull_reg)
                     | ({DATA_W{rd_pins}}  & pin_sync_reg)
                     | ({DATA_W{rd_count}} & count_reg);

   // ----------------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------------
   // reset zero except dir_reg (all ones), all bits writable
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= WDATA;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         duty0_reg <= DUTY_RESET;
      end else if (wr_duty0) begin
         duty0_reg <= WDATA;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         duty1_reg <= DUTY_RESET;
      end else if (wr_duty1) begin
         duty1_reg <= WDATA;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         dir_reg <= DIR_RESET;
      end else if (wr_dir) begin
         dir_reg <= WDATA;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         data_reg <= DATA_RESET;
      end else if (wr_data) begin
         data_reg <= WDATA;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         pull_reg <= PULL_RESET;
      end else if (wr_pull) begin
         pull_reg <= WDATA;
      end
   end

   // One cycle of read data, then zero again
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------------------
   // Free-running period counter
   // ----------------------------------------------------------------------
   // One counter drives both channels, so their periods stay aligned.
   // 256-clock period
   assign period_end = (count_reg == 8'hff);

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         count_reg <= 8'h00;
      end else begin
         count_reg <= count_reg + 8'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Channel modulators
   // ----------------------------------------------------------------------
   wire split_scheme_t scheme_sel;
   assign scheme_sel = ctrl_reg[BIT_SCHEME] ? SCHEME_6P2 : SCHEME_7P1;

   // The scheme travels with the duty and lands only at a period edge,
   // so a mode change never produces a torn period.
   pwm_chan_if chan0_bus ();
   pwm_chan_if chan1_bus ();

   assign chan0_bus.count      = count_reg;
   assign chan0_bus.period_end = period_end;
   assign chan0_bus.scheme     = scheme_sel;
   assign chan0_bus.duty       = duty0_reg;
   assign chan1_bus.count      = count_reg;
   assign chan1_bus.period_end = period_end;
   assign chan1_bus.scheme     = scheme_sel;
   assign chan1_bus.duty       = duty1_reg;

   pwm_chan u_chan0 (
      .REF_CLK (REF_CLK),
      .SRST    (SRST),
      .bus     (chan0_bus.chan)
   );

   pwm_chan u_chan1 (
      .REF_CLK (REF_CLK),
      .SRST    (SRST),
      .bus     (chan1_bus.chan)
   );

   // ----------------------------------------------------------------------
   // Pin-share selection
   // ----------------------------------------------------------------------
   wire logic [DATA_W-1:0] pwm_sel;
   wire logic [DATA_W-1:0] pwm_wave;

   // Bits without a modulator behave as plain port C.
   for (genvar b = 0; b < DATA_W; b++) begin : g_share
      if (b == CH0_PIN) begin : g_ch0
         assign pwm_sel[b]  = ctrl_reg[BIT_CH0_SEL];
         assign pwm_wave[b] = chan0_bus.wave;
      end else if (b == CH1_PIN) begin : g_ch1
         assign pwm_sel[b]  = ctrl_reg[BIT_CH1_SEL];
         assign pwm_wave[b] = chan1_bus.wave;
      end else begin : g_plain
         // No modulator on this bit
         assign pwm_sel[b]  = 1'b0;
         assign pwm_wave[b] = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Pad drive
   // ----------------------------------------------------------------------
   // Direction 1 means input; the enable is low while we drive the pad.
   for (genvar b = 0; b < DATA_W; b++) begin : g_pad
      assign pc_out_next[b]  = pwm_sel[b] ? (data_reg[b] & pwm_wave[b])
                                          : data_reg[b];
      assign pc_oe_n_next[b] = dir_reg[b];
   end

   // A registered pad keeps decode glitches off the pin, at a clock of lag.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         pc_out_reg <= DATA_RESET;
      end else begin
         pc_out_reg <= pc_out_next;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         pc_oe_n_reg <= DIR_RESET;
      end else begin
         pc_oe_n_reg <= pc_oe_n_next;
      end
   end

   // ----------------------------------------------------------------------
   // Pin input synchroniser
   // ----------------------------------------------------------------------
   // The pads are asynchronous; only the second stage is ever read.
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         pin_meta_reg <= 8'h00;
      end else begin
         pin_meta_reg <= PORTC_IN;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         pin_sync_reg <= 8'h00;
      end else begin
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign RDATA         = rdata_reg;
   assign PORTC_OUT     = pc_out_reg;
   assign PORTC_OE_N    = pc_oe_n_reg;
   assign PORTC_PULL_EN = pull_reg;

endmodule : dual_pwm_split_cycle

`default_nettype wire

// file: rtl/pwm_pkg.sv
// Constants, register map and types for the two-channel split-cycle PWM.
// Assumes a single 10 MHz system clock and a synchronous active-high reset.
`default_nettype none

package pwm_pkg;

   // ----------------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int COUNT_W = 8;

   // ----------------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL    = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_DUTY0   = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_DUTY1   = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_PC_DIR  = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_PC_DATA = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_PC_PULL = 3'h5;
   localparam logic [ADDR_W-1:0] OFS_PC_PINS = 3'h6;
   localparam logic [ADDR_W-1:0] OFS_COUNT   = 3'h7;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int BIT_SCHEME  = 7;
   localparam int BIT_CH1_SEL = 6;
   localparam int BIT_CH0_SEL = 5;
   localparam int CH0_PIN     = 5;
   localparam int CH1_PIN     = 6;

   // ----------------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------------
   localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
   localparam logic [DATA_W-1:0] DUTY_RESET = 8'h00;
   localparam logic [DATA_W-1:0] DIR_RESET  = 8'hff;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   localparam logic [DATA_W-1:0] PULL_RESET = 8'h00;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 100;
   localparam int FULL_PERIOD_CLKS = 256;
   localparam int SUB_6P2_CLKS     = 64;
   localparam int SUB_7P1_CLKS     = 128;
   localparam int FULL_PERIOD_NS   = FULL_PERIOD_CLKS * CLK_PERIOD_NS;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SCHEME_7P1 = 2'b01,
      SCHEME_6P2 = 2'b10
   } split_scheme_t;

endpackage : pwm_pkg

`default_nettype wire

// file: rtl/pwm_chan_if.sv
// Carrier between the PWM top and one channel modulator.
// Assumes both ends run on the same system clock.
`default_nettype none

interface pwm_chan_if;
   import pwm_pkg::*;

   logic [COUNT_W-1:0] count;
   logic               period_end;
   split_scheme_t      scheme;
   logic [DATA_W-1:0]  duty;
   logic               wave;

   modport top  (output count, output period_end, output scheme,
                 output duty, input wave);
   modport chan (input count, input period_end, input scheme,
                 input duty, output wave);
endinterface : pwm_chan_if

`default_nettype wire

// file: rtl/pwm_chan.sv
// One modulator channel: latches duty and scheme per full period and
// shapes the split-cycle waveform from the shared period counter.
// Assumes the counter and period_end come from the same clock domain.
`default_nettype none

module pwm_chan (
   input  wire logic REF_CLK,
   input  wire logic SRST,
   pwm_chan_if.chan  bus
);
   import pwm_pkg::*;

   logic [DATA_W-1:0] duty_reg;
   split_scheme_t     scheme_reg;
   logic              wave_reg;
   logic              wave_next;

   // ----------------------------------------------------------------------
   // Six-plus-two shaping
   // ----------------------------------------------------------------------
   wire logic [1:0] sub4_idx;
   wire logic [6:0] on_6p2;
   wire logic       wave_6p2;
   assign sub4_idx = bus.count[7:6];
   assign on_6p2   = {1'b0, duty_reg[7:2]}
                   + ((sub4_idx < duty_reg[1:0]) ? 7'h01 : 7'h00);
   assign wave_6p2 = {1'b0, bus.count[5:0]} < on_6p2;

   // ----------------------------------------------------------------------
   // Seven-plus-one shaping
   // ----------------------------------------------------------------------
   wire logic       sub2_idx;
   wire logic [7:0] on_7p1;
   wire logic       wave_7p1;
   assign sub2_idx = bus.count[7];
   assign on_7p1   = {1'b0, duty_reg[7:1]}
                   + (((sub2_idx ? 1'b1 : 1'b0) < duty_reg[0]) ? 8'h01
                                                               : 8'h00);
   assign wave_7p1 = {1'b0, bus.count[6:0]} < on_7p1;

   always_comb begin
      case (scheme_reg)
         SCHEME_6P2: wave_next = wave_6p2;
         SCHEME_7P1: wave_next = wave_7p1;
         default:    wave_next = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------
   // Period-aligned capture
   // ----------------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         duty_reg   <= DUTY_RESET;
         scheme_reg <= SCHEME_7P1;
         wave_reg   <= 1'b0;
      end else begin
         if (bus.period_end) begin
            duty_reg   <= bus.duty;
            scheme_reg <= bus.scheme;
         end
         wave_reg <= wave_next;
      end
   end

   assign bus.wave = wave_reg;

endmodule : pwm_chan

`default_nettype wire

// file: rtl/unused_placeholder_removed.sv
`default_nettype none
`default_nettype wire

// file: tb/pwm_split_checker.sv
// Port-level assertions for the split-cycle PWM top.
// Assumes the design counter is 0 in reset and then advances each clock.
`default_nettype none

module pwm_split_checker (
   input wire logic                        REF_CLK,
   input wire logic                        SRST,
   input wire logic [pwm_pkg::ADDR_W-1:0]  ADDR,
   input wire logic [pwm_pkg::DATA_W-1:0]  WDATA,
   input wire logic                        WR,
   input wire logic                        RD,
   input wire logic [pwm_pkg::DATA_W-1:0]  RDATA,
   input wire logic [pwm_pkg::DATA_W-1:0]  PORTC_IN,
   input wire logic [pwm_pkg::DATA_W-1:0]  PORTC_OUT,
   input wire logic [pwm_pkg::DATA_W-1:0]  PORTC_OE_N,
   input wire logic [pwm_pkg::DATA_W-1:0]  PORTC_PULL_EN
);
   timeunit 1ns;
   timeprecision 1ns;
   import pwm_pkg::*;

   // -------------------------------------------------------------
   // Mirrors of counter and registers
   // -------------------------------------------------------------
   logic [7:0] cnt_reg;
   logic [7:0] dat_reg;
   logic [7:0] ctl_reg;
   logic [1:0] quiet_reg;
   wire  logic [7:0] lag = cnt_reg - 8'h02;

   always_ff @(posedge REF_CLK) begin
      cnt_reg <= SRST ? 8'h00 : cnt_reg + 8'h01;
   end
   // Outputs settle within three clocks after any write
   always_ff @(posedge REF_CLK) begin
      if (SRST || WR)
         quiet_reg <= 2'h0;
      else if (quiet_reg != 2'h3)
         quiet_reg <= quiet_reg + 2'h1;
   end
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         dat_reg <= DATA_RESET;
      else if (WR && ADDR == OFS_PC_DATA)
         dat_reg <= WDATA;
   end
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         ctl_reg <= CTRL_RESET;
      else if (WR && ADDR == OFS_CTRL)
         ctl_reg <= WDATA;
   end

   // -------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SRST);

   sequence s_ctrl_wr; WR && ADDR == OFS_CTRL; endsequence
   sequence s_ctrl_rd; RD && ADDR == OFS_CTRL; endsequence
   property p_ctrl_rw;
      s_ctrl_wr ##1 s_ctrl_rd |=> RDATA == $past(WDATA, 2);
   endproperty
   property p_rdata_idle; !RD |=> RDATA == 8'h00; endproperty
   property p_count;
      RD && ADDR == OFS_COUNT |=> RDATA == $past(cnt_reg);
   endproperty
   property p_pins;
      $stable(PORTC_IN)[*3] ##0 (RD && ADDR == OFS_PC_PINS)
         |=> RDATA == $past(PORTC_IN);
   endproperty
   property p_dir_oe;
      WR && ADDR == OFS_PC_DIR |-> ##2 PORTC_OE_N == $past(WDATA, 2);
   endproperty
   property p_pull;
      WR && ADDR == OFS_PC_PULL |=> PORTC_PULL_EN == $past(WDATA);
   endproperty
   property p_plain;
      quiet_reg == 2'h3 |-> (PORTC_OUT & 8'h9f) == (dat_reg & 8'h9f);
   endproperty
   property p_force_low;
      quiet_reg == 2'h3 && !dat_reg[CH0_PIN] |-> !PORTC_OUT[CH0_PIN];
   endproperty
   property p_unsel;
      quiet_reg == 2'h3 && !ctl_reg[BIT_CH1_SEL]
         |-> PORTC_OUT[CH1_PIN] == dat_reg[CH1_PIN];
   endproperty
   property p_rise;
      quiet_reg == 2'h3 && ctl_reg[BIT_CH0_SEL] && $rose(PORTC_OUT[CH0_PIN])
         |-> lag[5:0] == 6'h00;
   endproperty

   a_ctrl_rw: assert property (p_ctrl_rw)
      else $error("control readback differs");
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero when idle");
   a_count: assert property (p_count)
      else $error("period counter off");
   a_pins: assert property (p_pins)
      else $error("pin levels read wrong");
   a_dir_oe: assert property (p_dir_oe)
      else $error("drive enable not from direction");
   a_pull: assert property (p_pull)
      else $error("pull-high enable wrong");
   a_plain: assert property (p_plain)
      else $error("plain port bit wrong");
   a_force_low: assert property (p_force_low)
      else $error("channel zero pin not forced low");
   a_unsel: assert property (p_unsel)
      else $error("unselected channel one pin wrong");
   a_rise: assert property (p_rise)
      else $error("wave rises mid sub-cycle");

endmodule : pwm_split_checker

bind dual_pwm_split_cycle pwm_split_checker u_pwm_split_checker (
   .REF_CLK(REF_CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
   .RD(RD), .RDATA(RDATA), .PORTC_IN(PORTC_IN), .PORTC_OUT(PORTC_OUT),
   .PORTC_OE_N(PORTC_OE_N), .PORTC_PULL_EN(PORTC_PULL_EN));

`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench: registers, pins and both wave schemes.
// Assumes the design counter resets to 0 and wraps every 256 clocks.
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pwm_pkg::*;

   logic       REF_CLK = 1'b0;
   logic       SRST = 1'b1;
   logic [2:0] ADDR = 3'h0;
   logic [7:0] WDATA = 8'h00;
   logic       WR = 1'b0;
   logic       RD = 1'b0;
   logic [7:0] PORTC_IN = 8'h00;
   logic [7:0] RDATA, PORTC_OUT, PORTC_OE_N, PORTC_PULL_EN;
   int         cnt = 0, err_total = 0, checks_done = 0, cycles = 0;
   int         seed = 37961;

   dual_pwm_split_cycle u_dual_pwm_split_cycle (
      .REF_CLK(REF_CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .PORTC_IN(PORTC_IN), .PORTC_OUT(PORTC_OUT),
      .PORTC_OE_N(PORTC_OE_N), .PORTC_PULL_EN(PORTC_PULL_EN));

   initial begin
      forever #50 REF_CLK = ~REF_CLK;
   end
   always @(posedge REF_CLK) begin
      cnt <= SRST ? 0 : (cnt + 1) % 256;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         close_out();
      end
   end

   // -------------------------------------------------------------
   // Bus, compare and model
   // -------------------------------------------------------------
   task automatic bus(input logic w, r, input logic [2:0] a,
                      input logic [7:0] d);
      @(posedge REF_CLK);
      WR <= w;
      RD <= r;
      ADDR <= a;
      WDATA <= d;
   endtask : bus
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp,
                         input string nm);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, a, 8'h00);
      #1 chk(nm, RDATA, exp);
   endtask : rd_chk
   function automatic logic wave(input int sch, d, c);
      int act;
      if (sch != 0)
         act = (d >> 2) + (((c >> 6) < (d & 3)) ? 1 : 0);
      else
         act = (d >> 1) + (((c >> 7) < (d & 1)) ? 1 : 0);
      return (sch != 0) ? ((c % 64) < act) : ((c % 128) < act);
   endfunction : wave
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      int k, i, d0, d1, sch, on1;
      logic [7:0] v;
      int dt[4] = '{0, 255, 65, 3};
      repeat (16) @(posedge REF_CLK);
      SRST <= 1'b0;
      rd_chk(OFS_CTRL, CTRL_RESET, "ctrl reset");
      rd_chk(OFS_DUTY0, DUTY_RESET, "duty0 reset");
      rd_chk(OFS_DUTY1, DUTY_RESET, "duty1 reset");
      chk("oe_n reset", PORTC_OE_N, DIR_RESET);
      $display("test reset values done");
      for (k = 0; k < 8; k++) begin
         v = $random(seed);
         bus(1'b1, 1'b0, OFS_CTRL, v);
         rd_chk(OFS_CTRL, v, "ctrl rw");
      end
      v = $random(seed);
      bus(1'b1, 1'b0, OFS_PC_PULL, v);
      rd_chk(OFS_PC_PULL, v, "pull rw");
      bus(1'b1, 1'b0, OFS_PC_PINS, ~v);
      PORTC_IN <= v;
      bus(1'b1, 1'b0, OFS_COUNT, v);
      bus(1'b0, 1'b0, OFS_COUNT, 8'h00);
      rd_chk(OFS_PC_PINS, v, "pins");
      bus(1'b0, 1'b1, OFS_COUNT, 8'h00);
      bus(1'b0, 1'b0, OFS_COUNT, 8'h00);
      #1 chk("count", RDATA, 8'((cnt + 255) % 256));
      v = $random(seed);
      bus(1'b1, 1'b0, OFS_CTRL, 8'h00);
      bus(1'b1, 1'b0, OFS_PC_DIR, 8'h00);
      bus(1'b1, 1'b0, OFS_PC_DATA, v);
      repeat (4) bus(1'b0, 1'b0, OFS_CTRL, 8'h00);
      #1 chk("plain out", PORTC_OUT, v);
      $display("test registers and pins done");
      // Duty written mid-period must only land at the next boundary
      while (cnt != 2) begin
         @(posedge REF_CLK);
         #1;
      end
      for (k = 0; k < 12; k++) begin
         sch = k % 2;
         on1 = (k % 3 != 0);
         d0 = (k < 8) ? dt[k / 2] : ($random(seed) & 255);
         d1 = $random(seed) & 255;
         bus(1'b1, 1'b0, OFS_CTRL, {sch[0], 7'h60});
         bus(1'b1, 1'b0, OFS_PC_DIR, 8'h9f);
         bus(1'b1, 1'b0, OFS_PC_DATA, {1'b0, on1[0], 6'h20});
         bus(1'b1, 1'b0, OFS_DUTY0, d0[7:0]);
         bus(1'b1, 1'b0, OFS_DUTY1, d1[7:0]);
         bus(1'b0, 1'b0, OFS_DUTY1, 8'h00);
         @(posedge REF_CLK);
         #1 chk("oe_n", PORTC_OE_N, 8'h9f);
         while (cnt != 2) begin
            @(posedge REF_CLK);
            #1;
         end
         for (i = 0; i < 256; i++) begin
            chk("ch0 wave", 8'(PORTC_OUT[CH0_PIN]),
                8'(wave(sch, d0, (cnt + 254) % 256)));
            chk("ch1 wave", 8'(PORTC_OUT[CH1_PIN]),
                8'(on1 & wave(sch, d1, (cnt + 254) % 256)));
            WR <= (i == 100);
            ADDR <= OFS_DUTY0;
            WDATA <= ~d0[7:0];
            @(posedge REF_CLK);
            #1;
         end
         $display("test wave scheme %0d duty %0d done", sch, d0);
      end
      close_out();
   end

endmodule : testbench

`default_nettype wire
